// ---- exec_pkg.sv ----
package exec_pkg;

   // opcode fields, upper bits of the 16-bit instruction word
   localparam logic [5:0] ROT_OPC      = 6'h10;   // 0100 00
   localparam int         ROT_OPC_LSB  = 10;
   localparam logic [6:0] FILL_OPC     = 7'h34;   // 0110 100
   localparam int         FILL_OPC_LSB = 9;
   localparam int         DEST_BIT     = 9;
   localparam int         BANKSEL_BIT  = 8;
   localparam logic [7:0] FILL_VALUE   = 8'hFF;

   // access bank: low file addresses map to the first bank, high to the last
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;

   // software register offsets
   localparam logic [1:0] ACC_OFS    = 2'h0;
   localparam logic [1:0] BANK_OFS   = 2'h1;
   localparam logic [1:0] STATUS_OFS = 2'h2;
   localparam logic [1:0] STATE_OFS  = 2'h3;

   // status field positions
   localparam int CARRY_POS  = 0;
   localparam int DCARRY_POS = 1;
   localparam int ZERO_POS   = 2;
   localparam int OVF_POS    = 3;
   localparam int NEG_POS    = 4;
   localparam int STATUS_W   = 5;

   // reset values
   localparam logic [7:0]          ACC_RESET    = 8'h00;
   localparam logic [7:0]          BANK_RESET   = 8'h00;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;

   // four phases of one instruction cycle
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } phase_type;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_ROT  = 2'b01,
      OP_FILL = 2'b10
   } op_type;

endpackage

// ---- result_unit.sv ----
`timescale 1ns/1ps
module result_unit (
   // operation and operand
   input  wire logic               rot_sel,
   input  wire logic [7:0]         operand,
   // result and flags
   output logic      [7:0]         result,
   output logic                    neg,
   output logic                    zero
);

   // rotate never touches carry; fill ignores the operand
   always_comb begin
      if (rot_sel) begin
         result = {operand[0], operand[7:1]};
      end else begin
         result = exec_pkg::FILL_VALUE;
      end
      neg  = result[7];
      zero = (result == 8'h00);
   end

endmodule // result_unit

// ---- rotate_right_and_set_ones_exec.sv ----
`timescale 1ns/1ps
module rotate_right_and_set_ones_exec #(
   parameter int BANK_W = 4
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rstn,
   // instruction issue
   input  wire logic                instr_valid,
   input  wire logic [15:0]         instr_word,
   output logic                     phase_q1,
   // file register port
   output logic                     file_rd_en,
   output logic      [BANK_W+7:0]   file_addr,
   input  wire logic [7:0]          file_rd_data,
   output logic                     file_wr_en,
   output logic      [7:0]          file_wr_data,
   // software register port
   input  wire logic [1:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata
);

   generate
      if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
         $error("BANK_W must lie between 1 and 8");
      end
   endgenerate

   exec_pkg::phase_type           phase_r;
   exec_pkg::op_type              op_r;
   logic                          dest_r;
   logic [7:0]                    operand_r;
   logic [7:0]                    result_r;
   logic                          neg_r;
   logic                          zero_r;
   logic [7:0]                    acc_r;
   logic [7:0]                    bank_r;
   logic [exec_pkg::STATUS_W-1:0] status_r;
   logic [7:0]                    alu_result;
   logic                          alu_neg;
   logic                          alu_zero;
   logic                          in_decode;
   logic                          in_write;

   assign in_decode = (phase_r == exec_pkg::PH_DECODE);
   assign in_write  = (phase_r == exec_pkg::PH_WRITE) &&
                      (op_r != exec_pkg::OP_NONE);
   assign phase_q1  = in_decode;

   // which instruction the word holds; anything else executes as a no-op
   function automatic exec_pkg::op_type decode_op(input logic [15:0] w);
      if (w[15:exec_pkg::ROT_OPC_LSB] == exec_pkg::ROT_OPC) begin
         decode_op = exec_pkg::OP_ROT;
      end else if (w[15:exec_pkg::FILL_OPC_LSB] == exec_pkg::FILL_OPC) begin
         decode_op = exec_pkg::OP_FILL;
      end else begin
         decode_op = exec_pkg::OP_NONE;
      end
   endfunction

   // full address: access bank splits at the midpoint, else bank pointer
   function automatic logic [BANK_W+7:0] bank_addr(
      input logic [15:0] w, input logic [7:0] bank);
      logic [BANK_W-1:0] b;
      b = bank[BANK_W-1:0];
      if (!w[exec_pkg::BANKSEL_BIT]) begin
         b = (w[7:0] < exec_pkg::ACCESS_SPLIT) ? '0 : '1;
      end
      bank_addr = {b, w[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer: free-running, one instruction per four clocks

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phase_r <= exec_pkg::PH_DECODE;
      end else begin
         case (phase_r)
            exec_pkg::PH_DECODE:  phase_r <= exec_pkg::PH_READ;
            exec_pkg::PH_READ:    phase_r <= exec_pkg::PH_PROCESS;
            exec_pkg::PH_PROCESS: phase_r <= exec_pkg::PH_WRITE;
            default:              phase_r <= exec_pkg::PH_DECODE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode phase: latch operation, destination and address

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op_r      <= exec_pkg::OP_NONE;
         dest_r    <= 1'b0;
         file_addr <= '0;
      end else if (in_decode) begin
         op_r <= instr_valid ? decode_op(instr_word) : exec_pkg::OP_NONE;
         // fill has no destination bit and always targets the register
         dest_r <= (decode_op(instr_word) == exec_pkg::OP_FILL) ?
                   1'b1 : instr_word[exec_pkg::DEST_BIT];
         file_addr <= bank_addr(instr_word, bank_r);
      end
   end

   // read phase: the register file answers combinationally
   assign file_rd_en = (phase_r == exec_pkg::PH_READ) &&
                       (op_r != exec_pkg::OP_NONE);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         operand_r <= 8'h00;
      end else if (file_rd_en) begin
         operand_r <= file_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // process phase

   result_unit u_result (
      .rot_sel (op_r == exec_pkg::OP_ROT),
      .operand (operand_r),
      .result  (alu_result),
      .neg     (alu_neg),
      .zero    (alu_zero)
   );

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_r <= 8'h00;
         neg_r    <= 1'b0;
         zero_r   <= 1'b0;
      end else if (phase_r == exec_pkg::PH_PROCESS) begin
         result_r <= alu_result;
         neg_r    <= alu_neg;
         zero_r   <= alu_zero;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write phase: file register or accumulator

   assign file_wr_en   = in_write && dest_r;
   assign file_wr_data = result_r;

   // core update beats a software write landing in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acc_r <= exec_pkg::ACC_RESET;
      end else if (in_write && op_r == exec_pkg::OP_ROT && !dest_r) begin
         acc_r <= result_r;
      end else if (reg_wr && reg_addr == exec_pkg::ACC_OFS) begin
         acc_r <= reg_wdata;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bank_r <= exec_pkg::BANK_RESET;
      end else if (reg_wr && reg_addr == exec_pkg::BANK_OFS) begin
         bank_r <= reg_wdata;
      end
   end

   // only N and Z move on a rotate; fill leaves the whole status alone
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_r <= exec_pkg::STATUS_RESET;
      end else if (in_write && op_r == exec_pkg::OP_ROT) begin
         status_r[exec_pkg::NEG_POS]  <= neg_r;
         status_r[exec_pkg::ZERO_POS] <= zero_r;
      end else if (reg_wr && reg_addr == exec_pkg::STATUS_OFS) begin
         status_r <= reg_wdata[exec_pkg::STATUS_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software read: data stand for exactly one cycle after the strobe

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == exec_pkg::ACC_OFS) begin
         reg_rdata <= acc_r;
      end else if (reg_addr == exec_pkg::BANK_OFS) begin
         reg_rdata <= bank_r;
      end else if (reg_addr == exec_pkg::STATUS_OFS) begin
         reg_rdata <= {3'h0, status_r};
      end else begin
         reg_rdata <= {4'h0, op_r, phase_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic sw_status_wr;
   assign sw_status_wr = reg_wr && reg_addr == exec_pkg::STATUS_OFS;

   chk_phase_order: assert property (
      @(posedge clock) disable iff (!rstn)
      in_decode |=> phase_r == exec_pkg::PH_READ ##1
         phase_r == exec_pkg::PH_PROCESS ##1 phase_r == exec_pkg::PH_WRITE
         ##1 in_decode)
      else $error("phase sequence broken");

   chk_rot_decode: assert property (
      @(posedge clock) disable iff (!rstn)
      in_decode && instr_valid && instr_word[15:10] == 6'h10
      |=> op_r == exec_pkg::OP_ROT && dest_r == $past(instr_word[9]))
      else $error("rotate not decoded");

   chk_fill_decode: assert property (
      @(posedge clock) disable iff (!rstn)
      in_decode && instr_valid && instr_word[15:9] == 7'h34
      |=> op_r == exec_pkg::OP_FILL && dest_r)
      else $error("fill not decoded");

   chk_rot_value: assert property (
      @(posedge clock) disable iff (!rstn)
      file_rd_en && op_r == exec_pkg::OP_ROT
      |=> ##1 in_write && result_r ==
         {$past(file_rd_data[0], 2), $past(file_rd_data[7:1], 2)})
      else $error("rotate result wrong");

   chk_fill_write: assert property (
      @(posedge clock) disable iff (!rstn)
      in_write && op_r == exec_pkg::OP_FILL
      |-> file_wr_en && file_wr_data == 8'hFF
         ##1 (status_r == $past(status_r) || $past(sw_status_wr)))
      else $error("fill wrong or flags moved");

   chk_acc_dest: assert property (
      @(posedge clock) disable iff (!rstn)
      in_write && op_r == exec_pkg::OP_ROT && !dest_r
      |-> !file_wr_en ##1 acc_r == $past(result_r))
      else $error("accumulator not written");

   chk_file_dest: assert property (
      @(posedge clock) disable iff (!rstn)
      in_write && op_r == exec_pkg::OP_ROT && dest_r
      |-> file_wr_en && file_wr_data == result_r)
      else $error("file register not written");

   chk_rot_flags: assert property (
      @(posedge clock) disable iff (!rstn)
      in_write && op_r == exec_pkg::OP_ROT
      |=> status_r[4] == $past(result_r[7])
         && status_r[2] == ($past(result_r) == 8'h00)
         && status_r[1:0] == $past(status_r[1:0])
         && status_r[3] == $past(status_r[3]))
      else $error("rotate flags wrong");

   chk_bank_select: assert property (
      @(posedge clock) disable iff (!rstn)
      in_decode |=> file_addr[7:0] == $past(instr_word[7:0]) &&
         file_addr[BANK_W+7:8] == ($past(instr_word[8]) ?
            $past(bank_r[BANK_W-1:0]) :
            ($past(instr_word[7]) ? {BANK_W{1'b1}} : {BANK_W{1'b0}})))
      else $error("bank selection wrong");

   chk_read_phase: assert property (
      @(posedge clock) disable iff (!rstn)
      file_rd_en |-> ##2 (file_wr_en || in_write))
      else $error("read not followed by write phase");

   chk_noop_quiet: assert property (
      @(posedge clock) disable iff (!rstn)
      in_decode && !(instr_valid && instr_word[15:10] == exec_pkg::ROT_OPC)
         && !(instr_valid && instr_word[15:9] == exec_pkg::FILL_OPC)
      |=> !file_rd_en ##2 !file_wr_en
         ##1 (acc_r == $past(acc_r) || $past(reg_wr)))
      else $error("refused word had an effect");

   chk_acc_hold: assert property (
      @(posedge clock) disable iff (!rstn)
      !(in_write && op_r == exec_pkg::OP_ROT && !dest_r)
         && !(reg_wr && reg_addr == exec_pkg::ACC_OFS)
      |=> acc_r == $past(acc_r))
      else $error("accumulator changed unasked");

   chk_status_hold: assert property (
      @(posedge clock) disable iff (!rstn)
      !(in_write && op_r == exec_pkg::OP_ROT) && !sw_status_wr
      |=> status_r == $past(status_r))
      else $error("status changed unasked");

endmodule // rotate_right_and_set_ones_exec

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;

   ////////////////////////////////////////////////////////////////////////////
   // clock, reset and design inputs
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [7:0]  file_rd_data = 8'h00;
   logic [1:0]  reg_addr = 2'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        phase_q1;
   logic        file_rd_en;
   logic [11:0] file_addr;
   logic        file_wr_en;
   logic [7:0]  file_wr_data;
   logic [7:0]  reg_rdata;
   int          n_errors = 0;
   int          compares = 0;

   // 200 MHz core clock
   always #2.5 clock = ~clock;

   rotate_right_and_set_ones_exec #(.BANK_W(4)) DUT (
      .clock        (clock),
      .rstn         (rstn),
      .instr_valid  (instr_valid),
      .instr_word   (instr_word),
      .phase_q1     (phase_q1),
      .file_rd_en   (file_rd_en),
      .file_addr    (file_addr),
      .file_rd_data (file_rd_data),
      .file_wr_en   (file_wr_en),
      .file_wr_data (file_wr_data),
      .reg_addr     (reg_addr),
      .reg_wdata    (reg_wdata),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_rdata    (reg_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // compare, verdict and bus tasks
   task automatic chk(input string name, input logic [11:0] seen,
                      input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // software write, one strobe cycle, then a free edge so that the next
   // call never drives the strobe twice in one time step
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr    <= 1'b0;
      @(posedge clock);
   endtask

   // software read, data stands only in the cycle after the strobe
   task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      @(negedge clock);
      chk("reg_rdata", 12'(reg_rdata), 12'(exp));
      @(negedge clock);
      chk("reg_rdata idle", 12'(reg_rdata), 12'h000);
      @(posedge clock);
   endtask

   // one instruction: the word waits until a decode edge takes it, then
   // every phase strobe is checked in its own cycle
   task automatic exec(input logic [15:0] w, input logic [7:0] rd,
                       input logic [11:0] addr, input logic rden,
                       input logic wr, input logic [7:0] wdata);
      int n;
      instr_valid <= 1'b1;
      instr_word  <= w;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (phase_q1 !== 1'b1 && n < 8);
      chk("phase_q1", 12'(phase_q1), 12'h001);
      @(posedge clock);
      instr_valid  <= 1'b0;
      file_rd_data <= rd;
      @(negedge clock);
      chk("phase_q1", 12'(phase_q1), 12'h000);
      chk("file_rd_en", 12'(file_rd_en), 12'(rden));
      chk("file_wr_en", 12'(file_wr_en), 12'h000);
      if (rden)
         chk("file_addr", file_addr, addr);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk("file_wr_en", 12'(file_wr_en), 12'(wr));
      if (wr)
         chk("file_wr_data", 12'(file_wr_data), 12'(wdata));
      // released read data must not look like the last value
      @(posedge clock);
      file_rd_data <= ~rd;
   endtask

   function automatic logic [7:0] rot(input logic [7:0] v);
      return {v[0], v[7:1]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      conclude();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      reg_write(exec_pkg::BANK_OFS, 8'h05);
      reg_write(exec_pkg::STATUS_OFS, 8'hEB);
      reg_read(exec_pkg::BANK_OFS, 8'h05);
      reg_read(exec_pkg::STATUS_OFS, 8'h0B);
      exec(16'h4334, 8'hD7, 12'h534, 1'b1, 1'b1, rot(8'hD7));
      reg_read(exec_pkg::STATUS_OFS, 8'h1B);
      exec(16'h407F, 8'hD7, 12'h07F, 1'b1, 1'b0, 8'h00);
      reg_read(exec_pkg::ACC_OFS, 8'hEB);
      exec(16'h4080, 8'h00, 12'hF80, 1'b1, 1'b0, 8'h00);
      reg_read(exec_pkg::ACC_OFS, 8'h00);
      reg_read(exec_pkg::STATUS_OFS, 8'h0F);
      exec(16'h4001, 8'h01, 12'h001, 1'b1, 1'b0, 8'h00);
      reg_read(exec_pkg::ACC_OFS, rot(8'h01));
      reg_read(exec_pkg::STATUS_OFS, 8'h1B);
      exec(16'h4312, 8'h00, 12'h512, 1'b1, 1'b1, 8'h00);
      reg_read(exec_pkg::STATUS_OFS, 8'h0F);
      exec(16'h6955, 8'h12, 12'h555, 1'b1, 1'b1, 8'hFF);
      exec(16'h68A0, 8'h34, 12'hFA0, 1'b1, 1'b1, 8'hFF);
      // state word right after a fill: fill op, decode phase
      reg_read(exec_pkg::STATE_OFS, 8'h08);
      reg_read(exec_pkg::STATUS_OFS, 8'h0F);
      // neighbouring opcodes must run as no-ops
      exec(16'h4400, 8'h55, 12'h000, 1'b0, 1'b0, 8'h00);
      exec(16'h6A00, 8'h55, 12'h000, 1'b0, 1'b0, 8'h00);
      exec(16'h3000, 8'h55, 12'h000, 1'b0, 1'b0, 8'h00);
      reg_read(exec_pkg::ACC_OFS, 8'h80);
      reg_read(exec_pkg::STATUS_OFS, 8'h0F);
      // mid-run reset: file strobes fall idle at once, phase_q1 rises with the decode phase, registers return to zero
      rstn <= 1'b0;
      @(negedge clock);
      chk("phase_q1", 12'(phase_q1), 12'h001);
      chk("file_rd_en", 12'(file_rd_en), 12'h000);
      chk("file_wr_en", 12'(file_wr_en), 12'h000);
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      reg_read(exec_pkg::ACC_OFS, 8'h00);
      reg_read(exec_pkg::BANK_OFS, 8'h00);
      reg_read(exec_pkg::STATUS_OFS, 8'h00);
      conclude();
   end

endmodule // tb
